/* src/cmd_buffer_consts.vh */
`ifndef CMD_BUFFER_CONSTS_VH
`define CMD_BUFFER_CONSTS_VH

// clock and timing
`define CLK_PERIOD_NS   10
`define T_ACT_NS        10
`define T_INACT_NS      15
// least time rounds up to whole cycles
`define ACT_CYC         ((`T_ACT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// checked data inputs per configuration, bit k holds input k+1
`define CHECK_MASK_A    28'hfff0f5f
`define CHECK_MASK_B    28'hfaf0fff

// fifo word layout, data in the low bits
`define FLD_DATA_LSB    0
`define FLD_ODT_LSB     28
`define FLD_CKE_LSB     30
`define FLD_CS_LSB      32
`define FLD_HOLD_BIT    34
`define WORD_W          35

// reset values of the outputs
`define RST_DATA        28'h0000000
`define RST_PAIR        2'h0
`define RST_ERR_N       1'b1

`endif

/* src/cmd_fifo.v */
// small synchronous fifo; depth must be a power of two so the pointers wrap
module cmd_fifo #(
  parameter WIDTH = 35,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output reg              in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;

  // handshakes on both sides
  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  // occupancy after this edge
  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      next_count = count - {{AW{1'b0}}, 1'b1};
  end

  // storage has no reset; only pointers, count and flags need one
  always @(posedge clk_i) begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // flags registered so ready and valid leave straight from flops
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr      <= {AW{1'b0}};
      rd_ptr      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      count       <= next_count;
      in_ready_o  <= (next_count != DEPTH[AW:0]);
      out_valid_o <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule // cmd_fifo

/* src/registered_cmd_buffer_parity.v */
`include "cmd_buffer_consts.vh"

module registered_cmd_buffer_parity #(
  parameter DATA_W     = 28,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              config_sel_i,
  input  wire              cs_gate_enable_i,
  input  wire              chip_select_in_0_i,
  input  wire              chip_select_in_1_i,
  input  wire [DATA_W-1:0] data_i,
  input  wire [1:0]        term_ctrl_in_i,
  input  wire [1:0]        clk_enable_in_i,
  input  wire              parity_in_i,
  input  wire              out_ready_i,
  output wire              cmd_ready_o,
  output reg  [DATA_W-1:0] buffered_out_a_o,
  output reg  [DATA_W-1:0] buffered_out_b_o,
  output reg  [1:0]        chip_select_out_0_o,
  output reg  [1:0]        chip_select_out_1_o,
  output reg  [1:0]        term_ctrl_out_o,
  output reg  [1:0]        clk_enable_out_o,
  output reg               low_power_state_o,
  output reg               parity_error_n_o
);

  // error output states, one-hot
  localparam [2:0] ST_CLEAR    = 3'b001;
  localparam [2:0] ST_LATCHED  = 3'b010;
  localparam [2:0] ST_LPM_HOLD = 3'b100;

  // quiet window in whole cycles, cut to the counter's width on purpose
  localparam integer ACT_CYC_FULL = `ACT_CYC;
  localparam [1:0]   ACT_CYC      = ACT_CYC_FULL[1:0];

  // ones count of the checked inputs, folded to odd or even
  function odd_ones;
    input [DATA_W-1:0] word;
    input              sel;
    reg   [DATA_W-1:0] mask;
    begin
      mask     = sel ? `CHECK_MASK_B : `CHECK_MASK_A;
      odd_ones = ^(word & mask);
    end
  endfunction

  wire                both_cs_high;
  wire                gate_hold;
  wire [`WORD_W-1:0]  in_word;
  wire [`WORD_W-1:0]  head_word;
  wire                head_valid;
  wire                head_pop;

  reg  [DATA_W-1:0]   cap_data;
  reg                 cap_chk;
  reg                 cap_sel;
  reg                 err_evt;
  reg                 err_prev;
  reg  [2:0]          err_state;
  reg                 hold_extra;
  reg  [1:0]          act_cnt;

  // input decode shared by the data and parity paths
  assign both_cs_high = chip_select_in_0_i & chip_select_in_1_i;
  assign gate_hold    = both_cs_high & cs_gate_enable_i;

  // the hold decision travels with its word so the output stage stays in step
  assign in_word = {gate_hold,
                    chip_select_in_1_i, chip_select_in_0_i,
                    clk_enable_in_i, term_ctrl_in_i, data_i};

  // a word is taken on every edge the fifo has room; full shows on cmd_ready_o
  cmd_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (1'b1),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   (in_word),
    .out_valid_o (head_valid),
    .out_ready_i (out_ready_i),
    .out_data_o  (head_word)
  );

  assign head_pop = head_valid & out_ready_i;

  // output stage: one load per popped word, outputs hold between loads
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buffered_out_a_o    <= `RST_DATA;
      buffered_out_b_o    <= `RST_DATA;
      chip_select_out_0_o <= `RST_PAIR;
      chip_select_out_1_o <= `RST_PAIR;
      term_ctrl_out_o     <= `RST_PAIR;
      clk_enable_out_o    <= `RST_PAIR;
    end else if (head_pop) begin
      // gated words leave the data outputs frozen to save switching
      if (!head_word[`FLD_HOLD_BIT]) begin
        buffered_out_a_o <= head_word[`FLD_DATA_LSB +: DATA_W];
        buffered_out_b_o <= head_word[`FLD_DATA_LSB +: DATA_W];
      end
      // select, termination and clock enable copies are never suspended
      chip_select_out_0_o <= {2{head_word[`FLD_CS_LSB]}};
      chip_select_out_1_o <= {2{head_word[`FLD_CS_LSB + 1]}};
      term_ctrl_out_o     <= head_word[`FLD_ODT_LSB +: 2];
      clk_enable_out_o    <= head_word[`FLD_CKE_LSB +: 2];
    end
  end

  // low power follows the pins of the current edge
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      low_power_state_o <= 1'b0;
    else
      low_power_state_o <= gate_hold;
  end

  // quiet window after reset release; inputs are held low by the controller
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      act_cnt <= ACT_CYC;
    else if (act_cnt != 2'h0)
      act_cnt <= act_cnt - 2'h1;
  end

  // parity stage 1, edge n: keep the word and whether a select was low
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_data <= `RST_DATA;
      cap_chk  <= 1'b0;
      cap_sel  <= 1'b0;
    end else begin
      cap_data <= data_i;
      cap_chk  <= ~both_cs_high & (act_cnt == 2'h0);
      cap_sel  <= config_sel_i;
    end
  end

  // parity stage 2, edge n+1: the late parity bit meets its data
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_evt  <= 1'b0;
      err_prev <= 1'b0;
    end else begin
      err_evt  <= cap_chk & (odd_ones(cap_data, cap_sel) ^ parity_in_i);
      err_prev <= err_evt;
    end
  end

  // error output, edge n+2: latching and stretching of the low level
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_state        <= ST_CLEAR;
      hold_extra       <= 1'b0;
      parity_error_n_o <= `RST_ERR_N;
    end else begin
      case (err_state)
        ST_CLEAR: begin
          if (err_evt) begin
            parity_error_n_o <= 1'b0;
            hold_extra       <= 1'b1;
            err_state        <= ST_LATCHED;
          end
        end
        ST_LATCHED: begin
          if (err_evt) begin
            // inside a run the low level ends with the run itself
            hold_extra <= ~err_prev;
          end else if (low_power_state_o) begin
            err_state <= ST_LPM_HOLD;
          end else if (hold_extra) begin
            hold_extra <= 1'b0;
          end else begin
            parity_error_n_o <= 1'b1;
            err_state        <= ST_CLEAR;
          end
        end
        ST_LPM_HOLD: begin
          // frozen while in low power, then three more cycles low after low_power_state_o falls
          if (!low_power_state_o) begin
            hold_extra <= 1'b1;
            err_state  <= ST_LATCHED;
          end
        end
        default: begin
          err_state        <= ST_CLEAR;
          hold_extra       <= 1'b0;
          parity_error_n_o <= `RST_ERR_N;
        end
      endcase
    end
  end

endmodule // registered_cmd_buffer_parity

/* sim/registered_cmd_buffer_parity_asserts.sv */
`include "cmd_buffer_consts.vh"
module cmd_buffer_checker #(
  parameter DATA_W = 28
) (
  input logic              clk_i,
  input logic              rst_i,
  input logic              config_sel_i,
  input logic              cs_gate_enable_i,
  input logic              chip_select_in_0_i,
  input logic              chip_select_in_1_i,
  input logic [DATA_W-1:0] data_i,
  input logic              parity_in_i,
  input logic [DATA_W-1:0] buffered_out_a_o,
  input logic [DATA_W-1:0] buffered_out_b_o,
  input logic [1:0]        chip_select_out_0_o,
  input logic              low_power_state_o,
  input logic              parity_error_n_o
);
  logic both_hi;
  // both selects idle means no parity check
  assign both_hi = chip_select_in_0_i & chip_select_in_1_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_outputs: assert property (disable iff (1'b0)
    rst_i |-> parity_error_n_o && !low_power_state_o && buffered_out_a_o == '0)
    else $error("outputs not cleared in reset");
  a_error_min_two: assert property ($fell(parity_error_n_o) |=> !parity_error_n_o)
    else $error("error output released too early");
  a_low_power_follow: assert property (1 |=>
    low_power_state_o == $past(both_hi & cs_gate_enable_i))
    else $error("low power state wrong");
  a_parity_detect: assert property ((!both_hi ##1
    ^{$past(data_i) & ($past(config_sel_i) ? `CHECK_MASK_B : `CHECK_MASK_A), parity_in_i})
    |-> ##2 !parity_error_n_o) else $error("parity error missed");
  a_low_power_hold: assert property (low_power_state_o && !parity_error_n_o
    |=> !parity_error_n_o) else $error("error released in low power");
  a_low_power_tail: assert property ($fell(low_power_state_o) && !parity_error_n_o
    |=> !parity_error_n_o) else $error("error released right after low power");
  a_copies_equal: assert property (buffered_out_a_o == buffered_out_b_o)
    else $error("data copies differ");
  a_select_copies: assert property (chip_select_out_0_o inside {2'h0, 2'h3})
    else $error("select copies differ");
endmodule // cmd_buffer_checker

bind registered_cmd_buffer_parity cmd_buffer_checker #(.DATA_W(DATA_W)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .config_sel_i(config_sel_i),
  .cs_gate_enable_i(cs_gate_enable_i), .chip_select_in_0_i(chip_select_in_0_i),
  .chip_select_in_1_i(chip_select_in_1_i), .data_i(data_i), .parity_in_i(parity_in_i),
  .buffered_out_a_o(buffered_out_a_o), .buffered_out_b_o(buffered_out_b_o),
  .chip_select_out_0_o(chip_select_out_0_o), .low_power_state_o(low_power_state_o),
  .parity_error_n_o(parity_error_n_o));

/* sim/cmd_controller_model.sv */
`include "cmd_buffer_consts.vh"
module cmd_controller_model (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        config_sel_i,
  input  logic [34:0] req_i,
  input  logic        bad_i,
  output logic [34:0] drive_o = '0,
  output logic        parity_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet;
  logic       bad_q;
  // word out first, its parity one cycle later; bad_i flips it on purpose
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet    <= 4'(`ACT_CYC);
      drive_o  <= '0; // defined levels, never floating
      parity_o <= 1'b0;
      bad_q    <= 1'b0;
    end else begin
      if (quiet != 4'h0) quiet <= quiet - 4'h1;
      drive_o  <= (quiet != 4'h0) ? '0 : req_i; // zeros after release
      bad_q    <= (quiet != 4'h0) ? 1'b0 : bad_i;
      parity_o <= ^{drive_o[27:0] & (config_sel_i ? `CHECK_MASK_B : `CHECK_MASK_A), bad_q};
    end
  end
endmodule // cmd_controller_model

/* sim/registered_cmd_buffer_parity_test.sv */
module registered_cmd_buffer_parity_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i = 1'b0, config_sel_i = 1'b0, out_ready_i = 1'b1, bad = 1'b0;
  logic [34:0] req = '0;
  wire  [34:0] d;
  wire         par, cmd_ready_o, low_power_state_o, parity_error_n_o;
  wire  [27:0] qa, qb;
  wire  [1:0]  cs0, cs1, odt, cke;
  logic [31:0] seed = 32'h4f;
  logic [27:0] prevd = '0;
  logic [35:0] last = '0, cur;
  logic [35:0] exq[$];
  int          bad_count = 0, comparisons = 0, refused = 0, base, k;
  logic [7:0]  got;
  logic [11:0] lp, ep;
  cmd_controller_model ctl (.clk_i(clk_i), .rst_i(rst_i), .config_sel_i(config_sel_i),
    .req_i(req), .bad_i(bad), .drive_o(d), .parity_o(par));
  registered_cmd_buffer_parity uut (.clk_i(clk_i), .rst_i(rst_i), .config_sel_i(config_sel_i),
    .cs_gate_enable_i(d[34]), .chip_select_in_0_i(d[32]), .chip_select_in_1_i(d[33]),
    .data_i(d[27:0]), .term_ctrl_in_i(d[29:28]), .clk_enable_in_i(d[31:30]),
    .parity_in_i(par), .out_ready_i(out_ready_i), .cmd_ready_o(cmd_ready_o),
    .buffered_out_a_o(qa), .buffered_out_b_o(qb), .chip_select_out_0_o(cs0),
    .chip_select_out_1_o(cs1), .term_ctrl_out_o(odt), .clk_enable_out_o(cke),
    .low_power_state_o(low_power_state_o), .parity_error_n_o(parity_error_n_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // gated words keep the old data but still pass selects, odt and cke
  function automatic logic [35:0] expect_out(logic [34:0] w);
    if (!(w[34] & w[33] & w[32])) prevd = w[27:0];
    return {prevd, {2{w[32]}}, {2{w[33]}}, w[29:28], w[31:30]};
  endfunction
  task automatic check_val(input logic [35:0] got_v, exp_v, input string what);
    comparisons++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got_v, exp_v);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input logic c0, c1, g, b, rdy);
    logic [31:0] r, s;
    r = rnd();
    s = rnd();
    @(posedge clk_i);
    req         <= {g, c1, c0, s[3:0], r[27:0]};
    bad         <= b;
    out_ready_i <= rdy;
    @(negedge clk_i);
  endtask
  // short warm-up on idle selects keeps the config change off live checks
  task automatic err_seq(input logic cfg, input int nbad, input logic [7:0] pat);
    for (int i = 0; i < 19; i++) begin
      if (i == 3) @(posedge clk_i) config_sel_i <= cfg;
      step(i < 3, i < 3, cfg, i >= 11 && i < 11 + nbad, 1'b1);
      if (i >= 11) got[i-11] = parity_error_n_o;
    end
    check_val({28'h0, got}, {28'h0, pat}, "error pattern");
  endtask
  // output changes are matched in order; words that change nothing are skipped
  always @(negedge clk_i) if (!rst_i) begin
    cur = {qa, cs0, cs1, odt, cke};
    if (cur !== last) begin
      while (exq.size() != 0 && exq[0] === last) void'(exq.pop_front());
      check_val(cur, (exq.size() != 0) ? exq.pop_front() : 'x, "outputs");
      last = cur;
    end
    if (cmd_ready_o === 1'b1) exq.push_back(expect_out(d));
    else refused++;
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #50000;
    bad_count++;
    end_of_test();
  end
  initial begin
    // raised off time zero so every reset process is already waiting for the edge
    #1 rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (200) begin
      k = int'(rnd());
      step(k[0], k[1], k[2], k[3] & k[4] & k[5], k[6] | k[7]);
    end
    base = refused;
    repeat (14) step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    check_val(36'(refused > base + 2), 36'h1, "fifo never refused");
    for (int c = 0; c < 2; c++) begin
      err_seq(c[0], 1, 8'hcf);
      err_seq(c[0], 3, 8'h8f);
    end
    // error right before low power: held through it and three cycles more
    for (int i = 0; i < 12; i++) begin
      step(i inside {[1:5]}, i inside {[1:5]}, i inside {[1:5]}, i == 0, 1'b1);
      lp[i] = low_power_state_o;
      ep[i] = parity_error_n_o;
    end
    check_val({24'h0, lp}, 36'h0f8, "low power window");
    check_val({24'h0, ep}, 36'h80f, "low power hold");
    repeat (20) step(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    end_of_test();
  end
endmodule // registered_cmd_buffer_parity_test
